/* pim_pkg.sv */
// constants, carriers and register map for the priority interrupt and mask logic
// assumes one 200 MHz clock; bit 0 of a 16-bit word in this map is the word's msb
package pim_pkg;

  // ********************
  // level counts and priority index layout
  // ********************
  localparam int NUM_EXT = 24;
  localparam int NUM_LVL = 27;
  localparam int IDX_W   = 5;
  localparam int LO_CNT  = 14;
  localparam int HI_CNT  = 10;
  localparam logic [IDX_W-1:0] IDX_INT   = 5'h00;
  localparam logic [IDX_W-1:0] IDX_EXT0  = 5'h01;
  localparam logic [IDX_W-1:0] IDX_TRACE = 5'h19;
  localparam logic [IDX_W-1:0] IDX_MAINT = 5'h1A;

  // ********************
  // vector locations
  // ********************
  localparam logic [15:0] VEC_INT     = 16'h0008;
  localparam logic [15:0] VEC_TRACE   = 16'h0009;
  localparam logic [15:0] VEC_MAINT   = 16'h000A;
  localparam logic [15:0] VEC_EXT_M1  = 16'h000A;
  localparam logic [15:0] MAINT_START = 16'h0001;

  // ********************
  // io control command decode
  // ********************
  localparam logic [4:0] AREA_INTR   = 5'h00;
  localparam logic [2:0] FUNC_CTRL   = 3'h4;
  localparam logic [2:0] MOD_MASK    = 3'h4;
  localparam logic [2:0] MOD_PROG    = 3'h5;

  // ********************
  // register offsets and reset values
  // ********************
  localparam logic [3:0] REG_IO_CONTROL_COMMAND_CTRL = 4'h0;
  localparam logic [3:0] REG_IO_CONTROL_COMMAND_ADDR = 4'h1;
  localparam logic [3:0] REG_SENSE_LSW = 4'h2;
  localparam logic [3:0] REG_MASK_LO   = 4'h3;
  localparam logic [3:0] REG_MASK_HI   = 4'h4;
  localparam logic [3:0] REG_STATUS    = 4'h5;
  localparam logic [NUM_EXT-1:0] MASK_RST = 24'hFFFFFF;
  localparam logic [15:0] WORD_RST = 16'h0000;

  typedef logic [15:0] pim_word_t;
  typedef pim_word_t [NUM_EXT-1:0] pim_lsw_t;

  typedef struct packed {
    logic [4:0] area;
    logic [2:0] func;
    logic [2:0] mod_op;
    logic [3:0] mod_mid;
    logic       grp_z;
  } pim_io_control_command_s;

  typedef struct packed {
    logic instr_done;
    logic xio_bsi;
    logic exit_branch;
  } pim_cpu_s;

  typedef struct packed {
    logic opcode;
    logic parity;
    logic channel_address_reg;
    logic protect;
  } pim_check_s;

endpackage

/* pim_rst_sync.sv */
// reset release synchroniser
// assumes reset_n_i may be asserted at any time
`timescale 1ns/10ps
module pim_rst_sync (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  output logic      rst_n_o
);

  logic meta_ff;

  // assert at once, release after two edges
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_ff <= 1'b0;
      rst_n_o <= 1'b0;
    end else begin
      meta_ff <= 1'b1;
      rst_n_o <= meta_ff;
    end
  end

endmodule

/* pim_prio_enc.sv */
// fixed priority encoder: lowest set index wins
// assumes index 0 is the most urgent level
`timescale 1ns/10ps
module pim_prio_enc (
  input  wire logic [pim_pkg::NUM_LVL-1:0] req_i,
  output logic                             found_o,
  output logic [pim_pkg::IDX_W-1:0]        idx_o
);

  always_comb begin
    found_o = 1'b0;
    idx_o   = '0;
    for (int k = pim_pkg::NUM_LVL - 1; k >= 0; k--) begin
      if (req_i[k]) begin
        found_o = 1'b1;
        idx_o   = pim_pkg::IDX_W'(k);
      end
    end
  end

endmodule

/* pim_core.sv */
// priority interrupt, masking and polling logic of the processor-controller
// assumes cpu strobes are one-cycle pulses synchronous to clk_i and status lines are levels
//
// Overview of operation
// - internal check level is highest priority
// - trace ranks below every customer level
// - maintenance key raises its own level
// - twenty-four external levels, each own vector
// - fixed priority numbers one through twenty-seven
// - no external interrupt after io/branch-store
// - internal unmaskable, but held one instruction
// - sensing internal status word clears it
// - masked external level cannot request service
// - mask command leaves device indicators alone
// - mask command decode and group select
// - address bit one masks, zero unmasks
// - all external levels masked at power-up
// - mask command leaves accumulator unchanged
// - poll groups alternately, resume after interrupt
// - programmed interrupt command decode and group
// - programmed command sets levels with one bits
// - masked levels get no programmed interrupt
// - any mask command cancels pending programmed levels
// - sense device with bit fifteen clears indicators (here the model clears a level on its own sense_clr_i strobe)
// - status word is sixteen ored lines
// - sense returns highest requesting level's word
// - equal or lower than in-service ignored
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/10ps
module pim_core (
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic [3:0]            reg_addr_i,
  input  wire logic [15:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [15:0]           reg_rdata_o,
  input  wire pim_pkg::pim_cpu_s     cpu_i,
  input  wire pim_pkg::pim_check_s   check_i,
  input  wire logic                  trace_en_i,
  input  wire logic                  maint_key_i,
  input  wire pim_pkg::pim_lsw_t     ext_lsw_i,
  output logic                       force_branch_o,
  output logic      [15:0]           vector_addr_o,
  output logic                       entry_indirect_o,
  output logic      [15:0]           entry_addr_o,
  output logic      [4:0]            prio_num_o
);

  // ********************
  // reset
  // ********************
  logic rst_n;

  pim_rst_sync u_rst (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .rst_n_o   (rst_n)
  );

  // ********************
  // state
  // ********************
  logic [pim_pkg::NUM_EXT-1:0] mask_ff;
  logic [pim_pkg::NUM_EXT-1:0] prog_ff;
  logic [pim_pkg::NUM_EXT-1:0] samp_ff;
  logic [pim_pkg::NUM_LVL-1:0] insvc_ff;
  logic [pim_pkg::NUM_LVL-1:0] nxt_insvc;
  logic [15:0]                 int_lsw_ff;
  pim_pkg::pim_io_control_command_s          io_control_command_ff;
  logic                        poll_hi_ff;
  logic                        holdoff_ff;
  logic                        maint_prev_ff;
  logic                        maint_pend_ff;

  // ********************
  // command decode
  // ********************
  logic cmd_exec;
  logic cmd_intr;
  logic cmd_mask;
  logic cmd_prog;
  logic sense_rd;

  assign cmd_exec = reg_wr_i && (reg_addr_i == pim_pkg::REG_IO_CONTROL_COMMAND_ADDR);
  assign cmd_intr = cmd_exec && (io_control_command_ff.area == pim_pkg::AREA_INTR)
                    && (io_control_command_ff.func == pim_pkg::FUNC_CTRL);
  assign cmd_mask = cmd_intr && (io_control_command_ff.mod_op == pim_pkg::MOD_MASK);
  assign cmd_prog = cmd_intr && (io_control_command_ff.mod_op == pim_pkg::MOD_PROG);
  assign sense_rd = reg_rd_i && (reg_addr_i == pim_pkg::REG_SENSE_LSW);

  // control word is held until the address word executes it
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      io_control_command_ff <= '0;
    end else if (reg_wr_i && (reg_addr_i == pim_pkg::REG_IO_CONTROL_COMMAND_CTRL)) begin
      io_control_command_ff <= pim_pkg::pim_io_control_command_s'(reg_wdata_i);
    end
  end

  // ********************
  // request vector and arbitration
  // ********************
  logic [pim_pkg::NUM_EXT-1:0] ext_req;
  logic [pim_pkg::NUM_LVL-1:0] req_vec;
  logic                        top_found;
  logic [pim_pkg::IDX_W-1:0]   top_idx;
  logic                        is_found;
  logic [pim_pkg::IDX_W-1:0]   is_idx;
  logic                        eligible;
  logic                        fire;

  assign ext_req = (samp_ff | prog_ff) & ~mask_ff;
  // internal is never gated by the mask
  assign req_vec = {maint_pend_ff, trace_en_i, ext_req, |int_lsw_ff};

  pim_prio_enc u_req_enc (
    .req_i   (req_vec),
    .found_o (top_found),
    .idx_o   (top_idx)
  );

  pim_prio_enc u_isv_enc (
    .req_i   (insvc_ff),
    .found_o (is_found),
    .idx_o   (is_idx)
  );

  // only the top request matters: anything below it is blocked too
  assign eligible = top_found && !holdoff_ff
                    && (!is_found || (top_idx < is_idx));
  assign fire     = cpu_i.instr_done && eligible;

  // ********************
  // instruction hold-off
  // ********************
  // the forced branch is itself a branch-store, so it shields its first routine instruction
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      holdoff_ff <= 1'b0;
    end else if (cpu_i.instr_done) begin
      holdoff_ff <= cpu_i.xio_bsi || fire;
    end
  end

  // ********************
  // group polling
  // ********************
  // the group in hand when a branch is forced is polled again next
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      poll_hi_ff <= 1'b0;
    end else if (!fire) begin
      poll_hi_ff <= !poll_hi_ff;
    end
  end

  // ********************
  // per-level mask, programmed request and sampling
  // ********************
  for (genvar i = 0; i < pim_pkg::NUM_EXT; i++) begin : g_ext
    localparam bit IS_LO = (i < pim_pkg::LO_CNT);
    localparam int BIT_N = IS_LO ? (15 - i) : (15 - (i - pim_pkg::LO_CNT));
    logic in_grp;
    logic hit;

    assign in_grp = IS_LO ? io_control_command_ff.grp_z : !io_control_command_ff.grp_z;
    assign hit    = in_grp && reg_wdata_i[BIT_N];

    // status lines are sampled only; the adapters keep the indicators
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        samp_ff[i] <= 1'b0;
      end else if (poll_hi_ff != IS_LO) begin
        samp_ff[i] <= |ext_lsw_i[i];
      end
    end

    // mask write never touches device indicators or the accumulator
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        mask_ff[i] <= pim_pkg::MASK_RST[i];
      end else if (cmd_mask && in_grp) begin
        mask_ff[i] <= reg_wdata_i[BIT_N];
      end
    end

    // a new programmed request beats the service clear in the same cycle
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        prog_ff[i] <= 1'b0;
      end else if (cmd_mask) begin
        prog_ff[i] <= 1'b0;
      end else if (cmd_prog && hit && !mask_ff[i]) begin
        prog_ff[i] <= 1'b1;
      end else if (fire && (top_idx == pim_pkg::IDX_W'(i + 1))) begin
        prog_ff[i] <= 1'b0;
      end
    end
  end

  // ********************
  // in-service tracking
  // ********************
  always_comb begin
    nxt_insvc = insvc_ff;
    if (cpu_i.exit_branch && is_found) begin
      nxt_insvc[is_idx] = 1'b0;
    end
    if (fire) begin
      nxt_insvc[top_idx] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      insvc_ff <= '0;
    end else begin
      insvc_ff <= nxt_insvc;
    end
  end

  // ********************
  // internal check status word
  // ********************
  // a check arriving with the sense read survives it
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      int_lsw_ff <= pim_pkg::WORD_RST;
    end else begin
      int_lsw_ff <= ((sense_rd && top_found && (top_idx == pim_pkg::IDX_INT)) ? 16'h0000 : int_lsw_ff)
                    | {check_i, 12'h000};
    end
  end

  // ********************
  // maintenance key
  // ********************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      maint_prev_ff <= 1'b0;
    end else begin
      maint_prev_ff <= maint_key_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      maint_pend_ff <= 1'b0;
    end else if (maint_key_i && !maint_prev_ff) begin
      maint_pend_ff <= 1'b1;
    end else if (fire && (top_idx == pim_pkg::IDX_MAINT)) begin
      maint_pend_ff <= 1'b0;
    end
  end

  // ********************
  // forced branch
  // ********************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      force_branch_o <= 1'b0;
    end else begin
      force_branch_o <= fire;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      vector_addr_o    <= 16'h0000;
      entry_indirect_o <= 1'b0;
      entry_addr_o     <= 16'h0000;
      prio_num_o       <= 5'h00;
    end else if (fire) begin
      prio_num_o       <= top_idx + 5'h01;
      entry_indirect_o <= (top_idx != pim_pkg::IDX_MAINT);
      entry_addr_o     <= 16'h0000;
      if (top_idx == pim_pkg::IDX_INT) begin
        vector_addr_o <= pim_pkg::VEC_INT;
      end else if (top_idx == pim_pkg::IDX_TRACE) begin
        vector_addr_o <= pim_pkg::VEC_TRACE;
      end else if (top_idx == pim_pkg::IDX_MAINT) begin
        vector_addr_o <= pim_pkg::VEC_MAINT;
        entry_addr_o  <= pim_pkg::MAINT_START;
      end else begin
        vector_addr_o <= pim_pkg::VEC_EXT_M1 + {11'h000, top_idx};
      end
    end
  end

  // ********************
  // register read port
  // ********************
  logic [15:0] sense_word;
  logic [15:0] mask_lo_word;
  logic [15:0] mask_hi_word;
  logic [15:0] status_word;

  // sense follows hardware priority, not anything in the command
  always_comb begin
    sense_word = 16'h0000;
    if (top_found && (top_idx == pim_pkg::IDX_INT)) begin
      sense_word = int_lsw_ff;
    end else if (top_found && (top_idx >= pim_pkg::IDX_EXT0) && (top_idx < pim_pkg::IDX_TRACE)) begin
      sense_word = ext_lsw_i[top_idx - pim_pkg::IDX_EXT0];
    end
  end

  always_comb begin
    mask_lo_word = 16'h0000;
    mask_hi_word = 16'h0000;
    for (int k = 0; k < pim_pkg::LO_CNT; k++) begin
      mask_lo_word[15-k] = mask_ff[k];
    end
    for (int k = 0; k < pim_pkg::HI_CNT; k++) begin
      mask_hi_word[15-k] = mask_ff[pim_pkg::LO_CNT+k];
    end
  end

  assign status_word = {poll_hi_ff, holdoff_ff, top_found, is_found, |prog_ff,
                        1'b0, top_idx, is_idx};

  // data stand for exactly the cycle after the read strobe
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 16'h0000;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_addr_i == pim_pkg::REG_IO_CONTROL_COMMAND_CTRL) begin
      reg_rdata_o <= 16'(io_control_command_ff);
    end else if (reg_addr_i == pim_pkg::REG_SENSE_LSW) begin
      reg_rdata_o <= sense_word;
    end else if (reg_addr_i == pim_pkg::REG_MASK_LO) begin
      reg_rdata_o <= mask_lo_word;
    end else if (reg_addr_i == pim_pkg::REG_MASK_HI) begin
      reg_rdata_o <= mask_hi_word;
    end else if (reg_addr_i == pim_pkg::REG_STATUS) begin
      reg_rdata_o <= status_word;
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

endmodule

/* pim_core_monitor.sv */
// port assertions for pim_core
// assumes bind to pim_core; reset is reset_n_i, one clock
`timescale 1ns/10ps
module pim_core_monitor (
  input wire logic              clk_i,
  input wire logic              reset_n_i,
  input wire logic [3:0]        reg_addr_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [15:0]       reg_rdata_o,
  input wire pim_pkg::pim_cpu_s cpu_i,
  input wire logic              force_branch_o,
  input wire logic [15:0]       vector_addr_o,
  input wire logic              entry_indirect_o,
  input wire logic [15:0]       entry_addr_o,
  input wire logic [4:0]        prio_num_o
);
  logic       hold_ff;
  logic       nest_ff;
  logic [4:0] last_ff;
  logic       fresh_ff;

  // ********************
  // helper state
  // ********************
  // an instruction end that fired also holds off the next one
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_ff <= 1'b0;
    end else if (cpu_i.instr_done) begin
      hold_ff <= cpu_i.xio_bsi;
    end else if (force_branch_o) begin
      hold_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nest_ff <= 1'b0;
      last_ff <= 5'h00;
    end else if (force_branch_o) begin
      nest_ff <= 1'b1;
      last_ff <= prio_num_o;
    end else if (cpu_i.exit_branch) begin
      nest_ff <= 1'b0;
    end
  end

  // masks hold reset value until the first command executes
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fresh_ff <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == pim_pkg::REG_IO_CONTROL_COMMAND_ADDR) begin
      fresh_ff <= 1'b0;
    end
  end

  // ********************
  // assertions
  // ********************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_blocked_done;
    cpu_i.instr_done && (hold_ff || force_branch_o);
  endsequence
  sequence s_lo_rd;
    reg_rd_i && reg_addr_i == pim_pkg::REG_MASK_LO && fresh_ff;
  endsequence
  sequence s_hi_rd;
    reg_rd_i && reg_addr_i == pim_pkg::REG_MASK_HI && fresh_ff;
  endsequence

  hold_off_a: assert property (s_blocked_done |=> !force_branch_o)
    else $error("branch taken at a held-off instruction end");
  branch_cause_a: assert property (force_branch_o |-> $past(cpu_i.instr_done))
    else $error("branch without an instruction end");
  maint_entry_a: assert property (force_branch_o && prio_num_o == 5'h1B |->
    vector_addr_o == pim_pkg::VEC_MAINT && !entry_indirect_o && entry_addr_o == pim_pkg::MAINT_START)
    else $error("maintenance entry wrong");
  ext_vector_a: assert property (force_branch_o && prio_num_o inside {[5'h02:5'h19]} |->
    vector_addr_o == {11'h000, prio_num_o} + 16'h0009 && entry_indirect_o)
    else $error("external vector wrong");
  int_vector_a: assert property (force_branch_o && prio_num_o == 5'h01 |->
    vector_addr_o == pim_pkg::VEC_INT && entry_indirect_o)
    else $error("internal vector wrong");
  trace_vector_a: assert property (force_branch_o && prio_num_o == 5'h1A |->
    vector_addr_o == pim_pkg::VEC_TRACE)
    else $error("trace vector wrong");
  nest_order_a: assert property (force_branch_o && nest_ff |-> prio_num_o < last_ff)
    else $error("nested branch not of higher priority");
  mask_lo_rst_a: assert property (s_lo_rd |=> reg_rdata_o == 16'hFFFC)
    else $error("lower mask not all set after reset");
  mask_hi_rst_a: assert property (s_hi_rd |=> reg_rdata_o == 16'hFFC0)
    else $error("upper mask not all set after reset");
  read_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside read cycle");
endmodule

bind pim_core pim_core_monitor mon_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cpu_i(cpu_i),
  .force_branch_o(force_branch_o), .vector_addr_o(vector_addr_o), .entry_indirect_o(entry_indirect_o),
  .entry_addr_o(entry_addr_o), .prio_num_o(prio_num_o));

/* pim_adapter_model.sv */
// adapters and devices feeding the level status lines
// assumes one indicator per device, sixteen devices per level
`timescale 1ns/10ps
module pim_adapter_model (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         set_i,
  input  wire logic         sense_clr_i,
  input  wire logic [4:0]   lvl_i,
  input  wire logic [3:0]   line_i,
  output pim_pkg::pim_lsw_t ext_lsw_o
);
  logic [15:0] ind_ff [pim_pkg::NUM_EXT];

  // indicators stay on while masked; only a clearing sense drops them
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ind_ff <= '{default: 16'h0000};
    end else if (set_i) begin
      ind_ff[lvl_i][line_i] <= 1'b1;
    end else if (sense_clr_i) begin
      ind_ff[lvl_i] <= 16'h0000;
    end
  end

  always_comb begin
    for (int j = 0; j < pim_pkg::NUM_EXT; j++) begin
      ext_lsw_o[j] = ind_ff[j];
    end
  end
endmodule

/* pim_core_tb_top.sv */
// self-checking bench for pim_core with the adapter model on its status lines
// assumes the package, design, monitor and model are compiled first
`timescale 1ns/10ps
module pim_core_tb_top;
  logic               clk_i = 1'b0;
  logic               reset_n_i = 1'b0;
  logic               reg_wr_i = 1'b0;
  logic               reg_rd_i = 1'b0;
  logic [3:0]         reg_addr_i = 4'h0;
  logic [15:0]        reg_wdata_i = 16'h0000;
  logic               trace_en_i = 1'b0;
  logic               maint_key_i = 1'b0;
  logic               set_i = 1'b0;
  logic               sense_clr_i = 1'b0;
  logic [4:0]         lvl_i = 5'h00;
  logic [3:0]         line_i = 4'h0;
  pim_pkg::pim_cpu_s  cpu_i = '0;
  pim_pkg::pim_check_s check_i = '0;
  pim_pkg::pim_lsw_t  ext_lsw_i;
  logic [15:0]        reg_rdata_o;
  logic [15:0]        vector_addr_o;
  logic [15:0]        entry_addr_o;
  logic               force_branch_o;
  logic               entry_indirect_o;
  logic [4:0]         prio_num_o;
  int                 errors = 0;
  int                 checks = 0;
  int                 cycles = 0;

  always #2.5 clk_i = ~clk_i;

  pim_core dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cpu_i(cpu_i), .check_i(check_i),
    .trace_en_i(trace_en_i), .maint_key_i(maint_key_i), .ext_lsw_i(ext_lsw_i), .force_branch_o(force_branch_o),
    .vector_addr_o(vector_addr_o), .entry_indirect_o(entry_indirect_o), .entry_addr_o(entry_addr_o),
    .prio_num_o(prio_num_o));

  pim_adapter_model model_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .set_i(set_i), .sense_clr_i(sense_clr_i),
    .lvl_i(lvl_i), .line_i(line_i), .ext_lsw_o(ext_lsw_i));

  // ********************
  // shared tasks
  // ********************
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    check(reg_rdata_o, exp);
  endtask

  // the address word write is what executes the command
  task io_control_command(input logic [2:0] m, input logic z, input logic [15:0] w);
    pim_pkg::pim_io_control_command_s c;
    c = '{area: pim_pkg::AREA_INTR, func: pim_pkg::FUNC_CTRL, mod_op: m, mod_mid: 4'h0, grp_z: z};
    wr(pim_pkg::REG_IO_CONTROL_COMMAND_CTRL, c);
    wr(pim_pkg::REG_IO_CONTROL_COMMAND_ADDR, w);
  endtask

  task dev(input logic s, input logic [4:0] l, input logic [3:0] n);
    @(posedge clk_i);
    set_i <= s;
    sense_clr_i <= !s;
    lvl_i <= l;
    line_i <= n;
    @(posedge clk_i);
    set_i <= 1'b0;
    sense_clr_i <= 1'b0;
  endtask

  // gap covers sampling lag plus both poll groups
  task step(input logic xb, input logic fb, input logic [4:0] p, input logic [15:0] v);
    repeat (6) @(posedge clk_i);
    cpu_i.instr_done <= 1'b1;
    cpu_i.xio_bsi <= xb;
    @(posedge clk_i);
    cpu_i.instr_done <= 1'b0;
    cpu_i.xio_bsi <= 1'b0;
    @(negedge clk_i);
    check({15'h0000, force_branch_o}, {15'h0000, fb});
    if (fb) begin
      check({11'h000, prio_num_o}, {11'h000, p});
      check(vector_addr_o, v);
      check({15'h0000, entry_indirect_o}, {15'h0000, p != 5'd27});
    end
  endtask

  task leave;
    @(posedge clk_i);
    cpu_i.exit_branch <= 1'b1;
    @(posedge clk_i);
    cpu_i.exit_branch <= 1'b0;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end

  // ********************
  // main sequence
  // ********************
  initial begin
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(pim_pkg::REG_MASK_LO, 16'hFFFC);
    rd(pim_pkg::REG_MASK_HI, 16'hFFC0);
    rd(4'hF, 16'h0000);
    io_control_command(pim_pkg::MOD_MASK, 1'b1, 16'h7FFC);
    io_control_command(pim_pkg::MOD_MASK, 1'b0, 16'h7FC0);
    rd(pim_pkg::REG_MASK_LO, 16'h7FFC);
    rd(pim_pkg::REG_MASK_HI, 16'h7FC0);
    dev(1'b1, 5'd0, 4'hF);
    step(1'b0, 1'b1, 5'd2, 16'h000B);
    rd(pim_pkg::REG_SENSE_LSW, 16'h8000);
    @(posedge clk_i);
    check_i.parity <= 1'b1;
    @(posedge clk_i);
    check_i.parity <= 1'b0;
    step(1'b0, 1'b0, 5'd0, 16'h0000);
    step(1'b0, 1'b1, 5'd1, 16'h0008);
    rd(pim_pkg::REG_SENSE_LSW, 16'h4000);
    rd(pim_pkg::REG_SENSE_LSW, 16'h8000);
    leave();
    leave();
    dev(1'b0, 5'd0, 4'h0);
    step(1'b0, 1'b0, 5'd0, 16'h0000);
    dev(1'b1, 5'd14, 4'h0);
    dev(1'b1, 5'd0, 4'hF);
    step(1'b0, 1'b1, 5'd2, 16'h000B);
    dev(1'b0, 5'd0, 4'h0);
    step(1'b0, 1'b0, 5'd0, 16'h0000);
    step(1'b0, 1'b0, 5'd0, 16'h0000);
    leave();
    step(1'b0, 1'b1, 5'd16, 16'h0019);
    dev(1'b0, 5'd14, 4'h0);
    step(1'b0, 1'b0, 5'd0, 16'h0000);
    leave();
    step(1'b1, 1'b0, 5'd0, 16'h0000);
    dev(1'b1, 5'd0, 4'hF);
    step(1'b0, 1'b0, 5'd0, 16'h0000);
    step(1'b0, 1'b1, 5'd2, 16'h000B);
    dev(1'b0, 5'd0, 4'h0);
    step(1'b0, 1'b0, 5'd0, 16'h0000);
    leave();
    io_control_command(pim_pkg::MOD_PROG, 1'b1, 16'h2000);
    dev(1'b1, 5'd1, 4'hF);
    step(1'b0, 1'b0, 5'd0, 16'h0000);
    io_control_command(pim_pkg::MOD_MASK, 1'b1, 16'h1FFC);
    step(1'b0, 1'b1, 5'd3, 16'h000C);
    dev(1'b0, 5'd1, 4'h0);
    step(1'b0, 1'b0, 5'd0, 16'h0000);
    leave();
    io_control_command(pim_pkg::MOD_PROG, 1'b1, 16'h2000);
    io_control_command(pim_pkg::MOD_MASK, 1'b1, 16'h1FFC);
    step(1'b0, 1'b0, 5'd0, 16'h0000);
    io_control_command(pim_pkg::MOD_PROG, 1'b1, 16'h2000);
    rd(pim_pkg::REG_IO_CONTROL_COMMAND_CTRL, 16'h04A1);
    step(1'b0, 1'b1, 5'd4, 16'h000D);
    step(1'b0, 1'b0, 5'd0, 16'h0000);
    leave();
    @(posedge clk_i);
    trace_en_i <= 1'b1;
    dev(1'b1, 5'd0, 4'hF);
    step(1'b0, 1'b1, 5'd2, 16'h000B);
    dev(1'b0, 5'd0, 4'h0);
    step(1'b0, 1'b0, 5'd0, 16'h0000);
    step(1'b0, 1'b0, 5'd0, 16'h0000);
    leave();
    step(1'b0, 1'b1, 5'd26, 16'h0009);
    @(posedge clk_i);
    trace_en_i <= 1'b0;
    step(1'b0, 1'b0, 5'd0, 16'h0000);
    leave();
    @(posedge clk_i);
    maint_key_i <= 1'b1;
    step(1'b0, 1'b1, 5'd27, 16'h000A);
    check(entry_addr_o, pim_pkg::MAINT_START);
    @(posedge clk_i);
    maint_key_i <= 1'b0;
    step(1'b0, 1'b0, 5'd0, 16'h0000);
    leave();
    wrap_up();
  end
endmodule
